//--- core/cpwm_top.sv
// Purpose: Three channel 10-bit PWM with complementary outputs
// Assumes: Single clock, AXI4-Lite register access, sync pin inputs
// Notes:   Output mode and pin polarity are static parameters
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Duty: high byte plus two low bits
// - Low write only fills hidden buffer
// - High write loads, copies buffer to low
// - Low read returns the buffer
// - Duty 3F0..3FF: high on, low off
// - Each pin selects I/O or PWM
// - Control bit picks single or complementary
// - Each output has own enable bit
// - Prescale and duty writable while running
// - Interlock: pair never both active
// - High and low polarity by parameter
// - PWM clock is clock over prescale+1
// - Sub-cycle 1024/512/256/128 PWM clocks by mode
// - One static mode for all channels
// - 9+1: coarse 9..1, fine bit 0
// - 8+2: coarse 9..2, fine 1..0
// - 7+3: coarse 9..3, fine 2..0
module cpwm_top #(
   parameter cpwm_pkg::cpwm_mode_e MODE = cpwm_pkg::MODE_10, // Output mode
   parameter logic HI_ACT_HIGH = 1'b1,        // High outputs active level
   parameter logic LO_ACT_HIGH = 1'b1         // Low outputs active level
) (
   input  wire logic        core_clk_i,       // System clock
   input  wire logic        rst_b_i,          // Async reset, active low
   input  wire logic [7:0]  s_axi_awaddr_i,   // Write address
   input  wire logic        s_axi_awvalid_i,  // Write address valid
   output logic             s_axi_awready_o,  // Write address ready
   input  wire logic [31:0] s_axi_wdata_i,    // Write data
   input  wire logic [3:0]  s_axi_wstrb_i,    // Write strobes
   input  wire logic        s_axi_wvalid_i,   // Write data valid
   output logic             s_axi_wready_o,   // Write data ready
   output logic [1:0]       s_axi_bresp_o,    // Write response
   output logic             s_axi_bvalid_o,   // Write response valid
   input  wire logic        s_axi_bready_i,   // Write response ready
   input  wire logic [7:0]  s_axi_araddr_i,   // Read address
   input  wire logic        s_axi_arvalid_i,  // Read address valid
   output logic             s_axi_arready_o,  // Read address ready
   output logic [31:0]      s_axi_rdata_o,    // Read data
   output logic [1:0]       s_axi_rresp_o,    // Read response
   output logic             s_axi_rvalid_o,   // Read data valid
   input  wire logic        s_axi_rready_i,   // Read data ready
   input  wire logic [5:0]  gpio_out_i,       // Port values in I/O use
   output logic [5:0]       pin_o,            // Shared pin levels
   output logic [5:0]       pin_function_select_o // 1 = pin carries PWM
);
   // Fine duty bits of the chosen mode
   function automatic int fine_bits(input cpwm_pkg::cpwm_mode_e m);
      case (m)
         cpwm_pkg::MODE_9P1: fine_bits = 1;
         cpwm_pkg::MODE_8P2: fine_bits = 2;
         cpwm_pkg::MODE_7P3: fine_bits = 3;
         default:            fine_bits = 0;
      endcase
   endfunction

   // Address of a channel's duty register
   function automatic logic [7:0] chan_addr(input int c, input logic lo);
      logic [7:0] a;
      a = cpwm_pkg::A_DUTY_BASE + 8'(c) * cpwm_pkg::A_CH_STRIDE;
      chan_addr = lo ? a + cpwm_pkg::A_LO_OFS : a;
   endfunction

   // Level of one channel for a duty and a counter value
   function automatic logic pwm_level(input logic [9:0] duty,
                                      input logic [9:0] cnt,
                                      input int k);
      logic [9:0]  sub;
      logic [9:0]  idx;
      logic [9:0]  fine;
      logic [10:0] thr;
      sub  = cnt & (10'h3FF >> k);             // Position in sub-cycle
      idx  = cnt >> (10 - k);                  // Modulation cycle index
      fine = duty & ~(10'h3FF << k);           // Fine part
      thr  = {1'b0, duty >> k} + ((idx < fine) ? 11'h001 : 11'h000);
      pwm_level = ({1'b0, sub} < thr) ||
                  (duty >= cpwm_pkg::DUTY_FULL_MIN);
   endfunction

   localparam int FINE_K = fine_bits(MODE);

   // Register file
   logic [7:0]          duty_hi_q [cpwm_pkg::NCH]; // Active high bytes
   logic [1:0]          duty_lo_q [cpwm_pkg::NCH]; // Active low bits
   logic [1:0]          lo_buf_q  [cpwm_pkg::NCH]; // Hidden low buffers
   cpwm_pkg::cpwm_ctrl_s ctrl_q;                   // Control
   logic [5:0]          pinsel_q;                  // Pin function select
   logic [5:0]          outen_q;                   // Per output enable
   // Bus state
   logic                aw_hold_q;                 // Address captured
   logic                w_hold_q;                  // Data captured
   logic [7:0]          awaddr_q;                  // Captured address
   logic [31:0]         wdata_q;                   // Captured data
   logic [3:0]          wstrb_q;                   // Captured strobes
   logic                bvalid_q;                  // Write answered
   logic [1:0]          bresp_q;                   // Write response
   logic                rvalid_q;                  // Read answered
   logic [31:0]         rdata_q;                   // Read data
   logic [1:0]          rresp_q;                   // Read response
   logic [31:0]         rd_word;                   // Read mux
   logic                rd_hit;                    // Read address mapped
   logic                wr_hit;                    // Write address mapped
   logic                wr_fire;                   // Write performed
   logic                wr_en;                     // Low byte written
   // PWM core
   logic [2:0]          pre_q;                     // Prescale counter
   logic                tick;                      // PWM clock enable
   logic [9:0]          cnt_q;                     // PWM counter
   logic [2:0]          h_act_q;                   // High outputs active
   logic [2:0]          l_act_q;                   // Low outputs active
   logic [5:0]          pin_q;                     // Pin levels

   // Handshake readies, combinational
   assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
   assign s_axi_wready_o  = !w_hold_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   // Registers are one byte wide, so only lane 0 matters
   assign wr_en = wr_fire && wstrb_q[0] && wr_hit;

   // Write address capture, either order with data
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= 8'h00;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_hold_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         w_hold_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_hold_q <= 1'b1;
         wdata_q  <= s_axi_wdata_i;
         wstrb_q  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   // Write address decode; status is read-only but answers OKAY
   always_comb begin
      wr_hit = (awaddr_q == cpwm_pkg::A_CTRL) ||
               (awaddr_q == cpwm_pkg::A_PINSEL) ||
               (awaddr_q == cpwm_pkg::A_OUTEN) ||
               (awaddr_q == cpwm_pkg::A_STATUS);
      for (int c = 0; c < cpwm_pkg::NCH; c++) begin
         if (awaddr_q == chan_addr(c, 1'b0) ||
             awaddr_q == chan_addr(c, 1'b1)) begin
            wr_hit = 1'b1;
         end
      end
   end

   // Write response
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bvalid_q <= 1'b0;
         bresp_q  <= cpwm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // Duty registers; writable any time, counter keeps running
   for (genvar c = 0; c < cpwm_pkg::NCH; c++) begin : g_duty
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            duty_hi_q[c] <= cpwm_pkg::DUTY_RST;
            duty_lo_q[c] <= 2'b00;
            lo_buf_q[c]  <= 2'b00;
         end else if (wr_en && awaddr_q == chan_addr(c, 1'b0)) begin
            duty_hi_q[c] <= wdata_q[7:0];
            duty_lo_q[c] <= lo_buf_q[c];
         end else if (wr_en && awaddr_q == chan_addr(c, 1'b1)) begin
            lo_buf_q[c]  <= wdata_q[1:0];
         end
      end
   end

   // Control, pin select and enable registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q   <= cpwm_pkg::CTRL_RST;
         pinsel_q <= cpwm_pkg::PINSEL_RST;
         outen_q  <= cpwm_pkg::OUTEN_RST;
      end else if (wr_en) begin
         case (awaddr_q)
            cpwm_pkg::A_CTRL: begin
               ctrl_q.comp <= wdata_q[cpwm_pkg::CTRL_COMP_BIT];
               ctrl_q.lock <= wdata_q[cpwm_pkg::CTRL_LOCK_BIT];
               ctrl_q.psc  <= wdata_q[cpwm_pkg::CTRL_PSC_LSB +: 3];
            end
            cpwm_pkg::A_PINSEL: pinsel_q <= wdata_q[5:0];
            cpwm_pkg::A_OUTEN:  outen_q  <= wdata_q[5:0];
            default: ;                             // Duty or status
         endcase
      end
   end

   // Read mux; the low register shows the buffer, not the active bits
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr_i)
         cpwm_pkg::A_CTRL: begin
            rd_word[cpwm_pkg::CTRL_COMP_BIT]     = ctrl_q.comp;
            rd_word[cpwm_pkg::CTRL_LOCK_BIT]     = ctrl_q.lock;
            rd_word[cpwm_pkg::CTRL_PSC_LSB +: 3] = ctrl_q.psc;
         end
         cpwm_pkg::A_PINSEL: rd_word[5:0] = pinsel_q;
         cpwm_pkg::A_OUTEN:  rd_word[5:0] = outen_q;
         cpwm_pkg::A_STATUS: begin
            rd_word[cpwm_pkg::STAT_CNT_LSB +: 10] = cnt_q;
            rd_word[cpwm_pkg::STAT_H_LSB +: 3]    = h_act_q;
            rd_word[cpwm_pkg::STAT_L_LSB +: 3]    = l_act_q;
         end
         default: rd_hit = 1'b0;
      endcase
      for (int c = 0; c < cpwm_pkg::NCH; c++) begin
         if (s_axi_araddr_i == chan_addr(c, 1'b0)) begin
            rd_word[7:0] = duty_hi_q[c];
            rd_hit       = 1'b1;
         end
         if (s_axi_araddr_i == chan_addr(c, 1'b1)) begin
            rd_word[1:0] = lo_buf_q[c];
            rd_hit       = 1'b1;
         end
      end
   end

   // Read answer, one cycle after the address is taken
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= cpwm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_hit ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // Prescaler; >= lets a smaller value take effect at once
   assign tick = (pre_q >= ctrl_q.psc);
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_q <= 3'h0;
      end else if (tick) begin
         pre_q <= 3'h0;
      end else begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // Free running 10-bit counter, wraps after the last count
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 10'h000;
      end else if (tick) begin
         cnt_q <= cnt_q + 10'h001;
      end
   end

   // Output stage per channel; pins and levels change together
   for (genvar c = 0; c < cpwm_pkg::NCH; c++) begin : g_out
      logic raw;                                   // Modulator level
      logic h_d;                                   // High active next
      logic l_d;                                   // Low active next
      // Sub-cycle split by mode; near full duty forced on
      assign raw = pwm_level({duty_hi_q[c], duty_lo_q[c]}, cnt_q,
                             FINE_K);
      assign h_d = raw && outen_q[2*c];
      // Interlock gate is kept even though ~raw already excludes it
      assign l_d = ctrl_q.comp && outen_q[2*c+1] && !raw &&
                   !(ctrl_q.lock && h_d);
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            h_act_q[c]   <= 1'b0;
            l_act_q[c]   <= 1'b0;
            pin_q[2*c]   <= 1'b0;
            pin_q[2*c+1] <= 1'b0;
         end else begin
            h_act_q[c]   <= h_d;
            l_act_q[c]   <= l_d;
            // Polarity applied last, I/O value when not selected
            pin_q[2*c]   <= pinsel_q[2*c] ?
                            (h_d ~^ HI_ACT_HIGH) : gpio_out_i[2*c];
            pin_q[2*c+1] <= pinsel_q[2*c+1] ?
                            (l_d ~^ LO_ACT_HIGH) : gpio_out_i[2*c+1];
         end
      end
   end

   // Outputs
   assign s_axi_bvalid_o        = bvalid_q;
   assign s_axi_bresp_o         = bresp_q;
   assign s_axi_rvalid_o        = rvalid_q;
   assign s_axi_rdata_o         = rdata_q;
   assign s_axi_rresp_o         = rresp_q;
   assign pin_o                 = pin_q;
   assign pin_function_select_o = pinsel_q;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic wr_hi0;                                   // High write, channel 0
   logic wr_lo0;                                   // Low write, channel 0
   assign wr_hi0 = wr_en && awaddr_q == chan_addr(0, 1'b0);
   assign wr_lo0 = wr_en && awaddr_q == chan_addr(0, 1'b1);

   property p_hi_copies_buf;
      wr_hi0 |=> duty_lo_q[0] == $past(lo_buf_q[0]) &&
                 duty_hi_q[0] == $past(wdata_q[7:0]);
   endproperty
   a_hi_copies_buf: assert property (p_hi_copies_buf)
      else $error("High write did not load duty pair");

   property p_lo_only_buf;
      wr_lo0 |=> $stable(duty_lo_q[0]) && lo_buf_q[0] == $past(wdata_q[1:0]);
   endproperty
   a_lo_only_buf: assert property (p_lo_only_buf)
      else $error("Low write touched active bits");

   property p_lo_reads_buf;
      (s_axi_arvalid_i && s_axi_arready_o &&
       s_axi_araddr_i == chan_addr(0, 1'b1))
         |=> s_axi_rvalid_o && s_axi_rdata_o[1:0] == $past(lo_buf_q[0]);
   endproperty
   a_lo_reads_buf: assert property (p_lo_reads_buf)
      else $error("Low read did not return buffer");

   property p_full_duty;
      ({duty_hi_q[0], duty_lo_q[0]} >= cpwm_pkg::DUTY_FULL_MIN &&
       outen_q[0] && pinsel_q[0] && pinsel_q[1])
         |=> pin_o[0] == HI_ACT_HIGH && pin_o[1] == !LO_ACT_HIGH;
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("Near full duty did not hold high output");

   property p_interlock;
      $past(ctrl_q.lock) |-> !(h_act_q[0] && l_act_q[0]);
   endproperty
   a_interlock: assert property (p_interlock)
      else $error("Both outputs of a pair active");

   sequence s_psc3;
      (tick && ctrl_q.psc == 3'd3) ##1 (!tick && ctrl_q.psc == 3'd3) [*3];
   endsequence
   // Only while the select stays at three; a new select acts on the running prescale count
   property p_prescale;
      s_psc3 ##1 (ctrl_q.psc == 3'd3) |-> tick;
   endproperty
   a_prescale: assert property (p_prescale)
      else $error("Prescale by four spacing wrong");

   property p_wrap;
      (tick && cnt_q == cpwm_pkg::CNT_LAST) |=> cnt_q == 10'h000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Counter did not wrap");

   property p_disabled_inactive;
      (!outen_q[0] && pinsel_q[0]) |=> pin_o[0] == !HI_ACT_HIGH;
   endproperty
   a_disabled_inactive: assert property (p_disabled_inactive)
      else $error("Disabled output not inactive");

   property p_single_mode;
      (!ctrl_q.comp && pinsel_q[1]) |=> pin_o[1] == !LO_ACT_HIGH;
   endproperty
   a_single_mode: assert property (p_single_mode)
      else $error("Low output active in single mode");

   property p_gpio_pass;
      !pinsel_q[2] |=> pin_o[2] == $past(gpio_out_i[2]);
   endproperty
   a_gpio_pass: assert property (p_gpio_pass)
      else $error("I/O pin did not pass port value");
endmodule // cpwm_top

//--- core/cpwm_pkg.sv
// Purpose: Shared constants and types of the complementary PWM block
// Assumes: AXI4-Lite slave, 32-bit data, 8-bit byte address
// Notes:   Every offset and field lives here, and the reset values of control, pin select, enable and high duty bytes
package cpwm_pkg;
   localparam int NCH    = 3;                  // Channels
   localparam int NPIN   = 6;                  // Shared pins
   localparam int DUTY_W = 10;                 // Duty width
   // Byte addresses
   localparam logic [7:0] A_DUTY_BASE = 8'h00; // Channel 0 high byte
   localparam logic [7:0] A_CH_STRIDE = 8'h08; // Per channel step
   localparam logic [7:0] A_LO_OFS    = 8'h04; // Low bits after high
   localparam logic [7:0] A_CTRL      = 8'h18; // Control
   localparam logic [7:0] A_PINSEL    = 8'h1C; // Pin function select
   localparam logic [7:0] A_OUTEN     = 8'h20; // Per output enable
   localparam logic [7:0] A_STATUS    = 8'h24; // Counter and levels
   // Control fields
   localparam int CTRL_COMP_BIT = 0;           // Complementary enable
   localparam int CTRL_LOCK_BIT = 1;           // Motor interlock
   localparam int CTRL_PSC_LSB  = 4;           // Prescale select 6:4
   // Status fields
   localparam int STAT_CNT_LSB = 0;            // Counter 9:0
   localparam int STAT_H_LSB   = 16;           // High levels 18:16
   localparam int STAT_L_LSB   = 20;           // Low levels 22:20
   // Reset values
   localparam logic [5:0] PINSEL_RST = 6'h00;  // All pins general I/O
   localparam logic [5:0] OUTEN_RST  = 6'h00;  // All outputs off
   localparam logic [7:0] DUTY_RST   = 8'h00;  // Duty zero
   // Near full duty threshold and last counter value
   localparam logic [9:0] DUTY_FULL_MIN = 10'h3F0;
   localparam logic [9:0] CNT_LAST      = 10'h3FF;
   // Responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Output modes, Gray along the usual order
   typedef enum logic [1:0] {
      MODE_10  = 2'b00,
      MODE_9P1 = 2'b01,
      MODE_8P2 = 2'b11,
      MODE_7P3 = 2'b10
   } cpwm_mode_e;

   // Control register contents
   typedef struct packed {
      logic [2:0] psc;                         // Clock prescale select
      logic       lock;                        // Motor interlock enable
      logic       comp;                        // Complementary enable
   } cpwm_ctrl_s;

   localparam cpwm_ctrl_s CTRL_RST = '{psc: 3'h0, lock: 1'b0, comp: 1'b0};
endpackage

//--- verif/cpwm_stage_model.sv
// Purpose: Gate driver stand-in, counts active time per pin
// Assumes: Active high pins, pin 2c high and 2c+1 low of pair c
// Notes:   Pins in I/O use are not counted as drive
`timescale 1ns/1ps
module cpwm_stage_model (
   input  wire logic        core_clk_i,    // System clock
   input  wire logic [5:0]  pin_i,         // Pin levels
   input  wire logic [5:0]  sel_i,         // 1 = pin carries PWM
   input  wire logic        count_en_i,    // Count window
   input  wire logic        clear_i,       // Clear counts
   output logic [15:0]      act_cnt_o [6], // Active clocks per pin
   output logic [15:0]      both_cnt_o     // Clocks with a pair both on
);
   logic [5:0] drv; // Driven and active
   // Pins taken as outputs; direction is set by software
   assign drv = pin_i & sel_i;
   // Count per pin; shoot-through counted separately
   always @(posedge core_clk_i) begin
      if (clear_i) begin
         both_cnt_o <= 16'h0000;
         foreach (act_cnt_o[k]) act_cnt_o[k] <= 16'h0000;
      end else if (count_en_i) begin
         foreach (act_cnt_o[k]) act_cnt_o[k] <= act_cnt_o[k] + 16'(drv[k]);
         // A shorted bridge leg would burn here
         both_cnt_o <= both_cnt_o + 16'(|(drv[4:0] & drv[5:1] & 5'h15));
      end
   end
endmodule // cpwm_stage_model

//--- verif/tb_top.sv
// Purpose: Self-checking bench of the complementary PWM block
// Assumes: Default mode and polarity, 40 MHz clock
// Notes:   Read results go through a queue to a monitor
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rst_b = 1'b0;        // Clock, reset
   logic [7:0]  awaddr = '0, araddr = '0;        // Addresses
   logic        awvalid = 0, wvalid = 0, arvalid = 0; // Requests
   logic        bready = 1, rready = 1;          // Always accepting
   logic [31:0] wdata = '0, rdata;               // Data
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;                    // Responses
   logic [5:0]  gpio = '0, pin, sel;             // Pin side
   logic        cen = 0, clr = 1;                // Model window
   logic [15:0] cnt [6];                         // Active clocks
   logic [15:0] both;                            // Overlap clocks
   logic [34:0] exp_q [$];                       // {check, resp, data}
   logic [1:0]  bexp_q [$];                      // Expected write answers
   logic [3:0]  strb = 4'hF;                     // Write strobes
   int          err_total = 0, n_compared = 0, cyc = 0;

   always #12.5 clk = ~clk;

   cpwm_top i_cpwm_top (.core_clk_i(clk), .rst_b_i(rst_b),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .gpio_out_i(gpio), .pin_o(pin),
      .pin_function_select_o(sel));

   cpwm_stage_model i_cpwm_stage_model (.core_clk_i(clk), .pin_i(pin),
      .sel_i(sel), .count_en_i(cen), .clear_i(clr), .act_cnt_o(cnt),
      .both_cnt_o(both));

   // Single compare point
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Write; each channel released once taken, answer to the monitor
   // No cycle budget here: only the hang guard ends a stuck wait
   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bexp_q.push_back(er);
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask

   // Read; expectation queued for the monitor
   task automatic rd(logic [7:0] a, logic [34:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      exp_q.push_back(e);
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
   endtask

   // Monitor: oldest expectation against each read answer
   always @(posedge clk) begin
      if (rvalid && rready && exp_q.size() > 0) begin
         chk("rresp", 32'(rresp), 32'(exp_q[0][33:32]));
         if (exp_q[0][34]) chk("rdata", rdata, exp_q[0][31:0]);
         void'(exp_q.pop_front());
      end
      if (bvalid && bready && bexp_q.size() > 0) begin
         chk("bresp", 32'(bresp), 32'(bexp_q[0]));
         void'(bexp_q.pop_front());
      end
   end

   // Count active clocks over one full output period
   task automatic measure(int c, int p, logic [9:0] d, logic [5:0] en);
      int per, h, l;
      per = 1024 * (p + 1);
      h = (d >= cpwm_pkg::DUTY_FULL_MIN) ? per : int'(d) * (p + 1);
      l = (d >= cpwm_pkg::DUTY_FULL_MIN) ? 0 : per - h;
      if (!en[2*c]) h = 0;
      if (!en[2*c+1]) l = 0;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      cen <= 1'b1;
      repeat (per) @(posedge clk);
      cen <= 1'b0;
      @(posedge clk);
      chk("high time", 32'(cnt[2*c]), 32'(h));
      chk("low time", 32'(cnt[2*c+1]), 32'(l));
      chk("overlap", 32'(both), 32'h0000_0000);
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      int i;
      logic [1:0] c;
      logic [9:0] d;
      logic [5:0] en;
      logic [7:0] hi;
      void'($urandom(17471));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(cpwm_pkg::A_CTRL, 35'h4_0000_0000);
      rd(cpwm_pkg::A_PINSEL, 35'h4_0000_0000);
      rd(cpwm_pkg::A_OUTEN, 35'h4_0000_0000);
      rd(8'h28, {1'b0, cpwm_pkg::RESP_SLVERR, 32'h0000_0000});
      gpio <= 6'($urandom);
      repeat (3) @(posedge clk);
      chk("io pin", 32'(pin), 32'(gpio));
      $display("test reset and io done");
      wr(cpwm_pkg::A_PINSEL, 8'h3F, cpwm_pkg::RESP_OKAY);
      // Lane 0 strobe low: register must keep its value
      strb <= 4'h0;
      wr(cpwm_pkg::A_PINSEL, 8'h00, cpwm_pkg::RESP_OKAY);
      strb <= 4'hF;
      rd(cpwm_pkg::A_PINSEL,
         {1'b1, cpwm_pkg::RESP_OKAY, 32'h0000_003F});
      wr(8'h28, 8'h00, cpwm_pkg::RESP_SLVERR);
      rd(cpwm_pkg::A_STATUS, 35'h0_0000_0000);
      for (i = 0; i < 8; i++) begin
         // First pass on channel 0 so the channel 0 checks all fire
         c = (i == 0) ? 2'h0 : 2'($urandom_range(2));
         d = (i == 0) ? 10'h3F0 : (i == 1) ? 10'h3EF : 10'($urandom);
         en = (i == 7) ? 6'h15 : 6'h3F;
         hi = cpwm_pkg::A_DUTY_BASE + 8'(c) * cpwm_pkg::A_CH_STRIDE;
         wr(cpwm_pkg::A_OUTEN, {2'b00, en}, cpwm_pkg::RESP_OKAY);
         // Pass six runs single output mode, lows must stay off
         wr(cpwm_pkg::A_CTRL, {1'b0, 3'(i), 2'b00, 1'(i), (i != 6)},
            cpwm_pkg::RESP_OKAY);
         wr(hi + 8'h04, {6'h00, d[1:0]}, cpwm_pkg::RESP_OKAY);
         wr(hi, d[9:2], cpwm_pkg::RESP_OKAY);
         // Buffer only; active duty must not move
         wr(hi + 8'h04, {6'h00, ~d[1:0]}, cpwm_pkg::RESP_OKAY);
         rd(hi + 8'h04, {1'b1, cpwm_pkg::RESP_OKAY, 30'h0000_0000,
            ~d[1:0]});
         repeat (16) @(posedge clk);
         measure(int'(c), i, d, (i == 6) ? en & 6'h15 : en);
         $display("test prescale %0d duty %h done", i, d);
      end
      conclude();
   end
endmodule // tb_top
